// *** shared/tups_consts.svh ***
// constants for the tunnel udp encapsulation and port selection ends
`ifndef TUPS_CONSTS_SVH
`define TUPS_CONSTS_SVH

// well-known tunnel control port, 1701
`define TUPS_WELL_KNOWN_PORT 16'h06A5

// ****************************************
// register offsets of the node end
// ****************************************
`define TUPS_OFS_CTRL 8'h00
`define TUPS_OFS_PORTS 8'h04
`define TUPS_OFS_WINDOW 8'h08
`define TUPS_OFS_CMD 8'h0C
`define TUPS_OFS_STATUS 8'h10
`define TUPS_OFS_PEERS 8'h14

// ****************************************
// field positions
// ****************************************
`define TUPS_CTRL_CAP_BIT 0
`define TUPS_CTRL_ADV_BIT 1
`define TUPS_CMD_DATA_BIT 0
`define TUPS_CMD_DIR_LSB 1
`define TUPS_CMD_DIR_MSB 2
`define TUPS_ST_UDP_BIT 0
`define TUPS_ST_V6_BIT 1
`define TUPS_ST_ADV_BIT 2
`define TUPS_ST_PEND_BIT 3
`define TUPS_ST_PRIO_LSB 4
`define TUPS_ST_PRIO_MSB 9

// ****************************************
// reset values
// ****************************************
`define TUPS_RST_CTRL 2'h3
`define TUPS_RST_CTL_PORT 16'h06A5
`define TUPS_RST_SESS_PORT 16'h06A5
`define TUPS_RST_WIN_LO 16'hC000
`define TUPS_RST_WIN_HI 16'hC0FF
`define TUPS_RST_PRIO 6'h00

`endif

// *** shared/tups_pkg.sv ***
// types shared by both ends of the tunnel udp port selection link
package tups_pkg;

  // kind of tunnel packet described on the link
  typedef enum logic [2:0] {
    TUPS_CONN_REQ = 3'h0,
    TUPS_CONN_REP = 3'h1,
    TUPS_CTRL = 3'h2,
    TUPS_SESS_REQ = 3'h3,
    TUPS_SESS_REP = 3'h4,
    TUPS_DATA = 3'h5
  } tups_kind_e;

  // session flavour
  typedef enum logic [1:0] {
    TUPS_DN_UNI = 2'h0,
    TUPS_DN_GRP = 2'h1,
    TUPS_UP = 2'h2
  } tups_dir_e;

  // one packet header descriptor; udp_hdr is {src, dst}, first wire byte in [31:24]
  typedef struct packed {
    tups_kind_e kind;
    tups_dir_e dir;
    logic v6;
    logic udp;
    logic [5:0] dscp;
    logic [31:0] udp_hdr;
    logic attr_vld;
    logic [15:0] attr_port;
    logic grp_vld;
    logic [15:0] grp_port;
    logic prio_vld;
    logic [5:0] prio;
  } tups_pkt_s;

endpackage

// *** shared/tups_link_if.sv ***
// link between the headend core end and the remote node end
`timescale 1ns/100ps
interface tups_link_if;
  logic c2n_vld;
  tups_pkg::tups_pkt_s c2n_pkt;
  logic n2c_vld;
  tups_pkg::tups_pkt_s n2c_pkt;
  logic node_cap;

  modport node (
    input c2n_vld,
    input c2n_pkt,
    output n2c_vld,
    output n2c_pkt,
    output node_cap
  );

  modport core (
    output c2n_vld,
    output c2n_pkt,
    input n2c_vld,
    input n2c_pkt,
    input node_cap
  );
endinterface // tups_link_if

// *** design/tups_node.sv ***
// remote node end: udp encapsulation decision and port selection
// What the two ends do
// RULE1 - core marks headers with configured priority code
// RULE2 - both ends build and parse ipv6 headers
// RULE3 - ipv6 keeps same address and priority behaviour
// RULE4 - node handles no-udp; reports udp capability
// RULE5 - core uses udp only when enabled, capable
// RULE6 - node uses udp after udp connection request
// RULE7 - core requests to port 1701, ephemeral source
// RULE8 - node replies to host port, own source
// RULE9 - core control goes host port to node port
// RULE10 - node control goes node port to host port
// RULE11 - each side prefers 1701 as control port
// RULE12 - node may advertise its unicast receive port
// RULE13 - core sends to advertised port, else node port
// RULE14 - core picks group port inside group window
// RULE15 - node never advertises window ports for unicast
// RULE16 - core keeps one fixed downstream source port
// RULE17 - node probes go to core port, else host
// RULE18 - node upstream goes to core port, else host
// RULE19 - node keeps one fixed upstream source port
// RULE20 - core upstream-session sends to node port fallback
// RULE21 - node control priority from attribute, else zero
// RULE22 - udp header ports in network byte order
`timescale 1ns/100ps
`include "tups_consts.svh"
module tups_node #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  tups_link_if.node link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import tups_pkg::*;

  // ****************************************
  // elaboration check
  // ****************************************
  if (ADDR_W < 5 || ADDR_W > 32)
  begin : g_bad_addr
    $error("tups_node: ADDR_W must lie between 5 and 32");
  end

  logic acc;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [1:0] ctrl_r;
  logic [15:0] own_ctl_port_r;
  logic [15:0] own_sess_port_r;
  logic [15:0] win_lo_r;
  logic [15:0] win_hi_r;
  logic cmd_pend_r;
  logic cmd_data_r;
  tups_dir_e cmd_dir_r;
  logic udp_on_r;
  logic v6_r;
  logic [15:0] host_port_r;
  logic core_adv_vld_r;
  logic [15:0] core_adv_port_r;
  logic [5:0] prio_r;
  logic rep_pend_r;
  logic srep_pend_r;
  tups_dir_e srep_dir_r;
  logic tx_vld_r;
  tups_pkt_s tx_pkt_r;
  tups_pkt_s pkt_nxt;
  logic take_rep;
  logic take_srep;
  logic take_cmd;
  logic rx_req;
  logic rx_sreq;
  logic cmd_wr;
  logic [15:0] core_dst;

  // port lies inside the group port window
  function automatic logic in_window(input logic [15:0] p, input logic [15:0] lo, input logic [15:0] hi);
    in_window = (p >= lo) && (p <= hi);
  endfunction

  // udp header words, source first on the wire
  function automatic logic [31:0] mk_udp(input logic on, input logic [15:0] src, input logic [15:0] dst);
    mk_udp = on ? {src, dst} : 32'h00000000;
  endfunction

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign acc = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cmd_wr = wr_pend_r && (wr_addr_r == `TUPS_OFS_CMD);

  // address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= acc & hwrite;
      wr_addr_r <= {{(8 - 5){1'b0}}, haddr[4:2], 2'b00};
    end
  end

  // configuration registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= `TUPS_RST_CTRL;
      own_ctl_port_r <= `TUPS_RST_CTL_PORT; // [RULE11]
      own_sess_port_r <= `TUPS_RST_SESS_PORT;
      win_lo_r <= `TUPS_RST_WIN_LO;
      win_hi_r <= `TUPS_RST_WIN_HI;
    end
    else if (wr_pend_r)
    begin
      case (wr_addr_r)
        `TUPS_OFS_CTRL: ctrl_r <= hwdata[1:0];
        `TUPS_OFS_PORTS:
        begin
          own_ctl_port_r <= hwdata[15:0];
          own_sess_port_r <= hwdata[31:16]; // one fixed source per session [RULE19]
        end
        `TUPS_OFS_WINDOW:
        begin
          win_lo_r <= hwdata[15:0];
          win_hi_r <= hwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (acc && !hwrite)
    begin
      case (haddr[4:2])
        3'h0: hrdata <= {30'h0, ctrl_r};
        3'h1: hrdata <= {own_sess_port_r, own_ctl_port_r};
        3'h2: hrdata <= {win_hi_r, win_lo_r};
        3'h3: hrdata <= {28'h0000000, cmd_pend_r, cmd_dir_r, cmd_data_r};
        3'h4: hrdata <= {22'h0, prio_r, cmd_pend_r, core_adv_vld_r, v6_r, udp_on_r};
        3'h5: hrdata <= {core_adv_port_r, host_port_r};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // software command
  // ****************************************
  // a new command wins over the take of the old one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_pend_r <= 1'b0;
      cmd_data_r <= 1'b0;
      cmd_dir_r <= TUPS_DN_UNI;
    end
    else if (cmd_wr)
    begin
      cmd_pend_r <= 1'b1;
      cmd_data_r <= hwdata[`TUPS_CMD_DATA_BIT];
      cmd_dir_r <= tups_dir_e'(hwdata[`TUPS_CMD_DIR_MSB:`TUPS_CMD_DIR_LSB]);
    end
    else if (take_cmd)
      cmd_pend_r <= 1'b0;
  end

  // ****************************************
  // receive side
  // ****************************************
  assign rx_req = link.c2n_vld && (link.c2n_pkt.kind == TUPS_CONN_REQ);
  assign rx_sreq = link.c2n_vld && (link.c2n_pkt.kind == TUPS_SESS_REQ);
  assign link.node_cap = ctrl_r[`TUPS_CTRL_CAP_BIT]; // capability report [RULE4]

  // connection state learnt from the core's request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      udp_on_r <= 1'b0;
      v6_r <= 1'b0;
      host_port_r <= `TUPS_WELL_KNOWN_PORT;
      prio_r <= `TUPS_RST_PRIO;
    end
    else if (rx_req)
    begin
      udp_on_r <= ctrl_r[`TUPS_CTRL_CAP_BIT] & link.c2n_pkt.udp; // [RULE6] [RULE4]
      v6_r <= link.c2n_pkt.v6; // [RULE2]
      host_port_r <= link.c2n_pkt.udp_hdr[31:16]; // request source port [RULE8]
      prio_r <= link.c2n_pkt.prio_vld ? link.c2n_pkt.prio : `TUPS_RST_PRIO; // [RULE21]
    end
    else if (link.c2n_vld && link.c2n_pkt.prio_vld)
      prio_r <= link.c2n_pkt.prio; // [RULE21]
  end

  // core's advertised session port
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_adv_vld_r <= 1'b0;
      core_adv_port_r <= 16'h0000;
    end
    else if (rx_req)
      core_adv_vld_r <= 1'b0;
    else if (rx_sreq)
    begin
      core_adv_vld_r <= link.c2n_pkt.attr_vld;
      core_adv_port_r <= link.c2n_pkt.attr_port;
    end
  end

  // pending replies; arrival wins over the take
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rep_pend_r <= 1'b0;
      srep_pend_r <= 1'b0;
      srep_dir_r <= TUPS_DN_UNI;
    end
    else
    begin
      if (rx_req)
        rep_pend_r <= 1'b1;
      else if (take_rep)
        rep_pend_r <= 1'b0;
      if (rx_sreq)
      begin
        srep_pend_r <= 1'b1;
        srep_dir_r <= link.c2n_pkt.dir;
      end
      else if (take_srep)
        srep_pend_r <= 1'b0;
    end
  end

  // ****************************************
  // transmit side
  // ****************************************
  assign take_rep = rep_pend_r && !rx_req;
  assign take_srep = srep_pend_r && !rep_pend_r && !rx_sreq;
  assign take_cmd = cmd_pend_r && !rep_pend_r && !srep_pend_r && !cmd_wr;
  assign core_dst = core_adv_vld_r ? core_adv_port_r : host_port_r; // [RULE17] [RULE18]

  // next descriptor: reply, then session reply, then command
  always_comb
  begin
    pkt_nxt = '0;
    pkt_nxt.v6 = v6_r; // [RULE2] [RULE3]
    pkt_nxt.udp = udp_on_r; // [RULE4] [RULE6]
    pkt_nxt.dscp = prio_r; // same marking under either ip version [RULE3] [RULE21]
    pkt_nxt.kind = TUPS_CTRL;
    pkt_nxt.udp_hdr = mk_udp(udp_on_r, own_ctl_port_r, host_port_r); // [RULE10] [RULE22]
    if (take_rep)
      pkt_nxt.kind = TUPS_CONN_REP; // [RULE8]
    else if (take_srep)
    begin
      pkt_nxt.kind = TUPS_SESS_REP;
      pkt_nxt.dir = srep_dir_r;
      pkt_nxt.attr_port = own_sess_port_r;
      pkt_nxt.attr_vld = ctrl_r[`TUPS_CTRL_ADV_BIT] && (srep_dir_r != TUPS_DN_GRP) &&
                         !in_window(own_sess_port_r, win_lo_r, win_hi_r); // [RULE12] [RULE15] [RULE19]
    end
    else if (cmd_data_r)
    begin
      pkt_nxt.kind = TUPS_DATA;
      pkt_nxt.dir = cmd_dir_r;
      pkt_nxt.udp_hdr = mk_udp(udp_on_r, own_sess_port_r, core_dst); // [RULE17] [RULE18] [RULE19]
    end
  end

  // one registered descriptor per cycle toward the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_vld_r <= 1'b0;
      tx_pkt_r <= '0;
    end
    else
    begin
      tx_vld_r <= take_rep | take_srep | take_cmd;
      tx_pkt_r <= pkt_nxt;
    end
  end

  assign link.n2c_vld = tx_vld_r;
  assign link.n2c_pkt = tx_pkt_r;
endmodule // tups_node

// *** design/tups_core.sv ***
// headend core end: udp decision, port negotiation and priority marking
`timescale 1ns/100ps
`include "tups_consts.svh"
module tups_core (
  input wire logic hclk,
  input wire logic hresetn,
  tups_link_if.core link,
  input wire logic cfg_udp_en,
  input wire logic cfg_v6,
  input wire logic [5:0] cfg_dscp,
  input wire logic [15:0] cfg_ctl_port,
  input wire logic [15:0] cfg_src_port,
  input wire logic cfg_adv_src,
  input wire logic [15:0] cfg_grp_lo,
  input wire logic [15:0] cfg_grp_hi,
  input wire logic [15:0] cfg_grp_pick,
  input wire logic cmd_vld,
  input wire tups_pkg::tups_kind_e cmd_kind,
  input wire tups_pkg::tups_dir_e cmd_dir,
  output logic udp_on,
  output logic [15:0] node_ctl_port,
  output logic node_adv_vld,
  output logic [15:0] node_adv_port,
  output logic rx_vld,
  output tups_pkg::tups_pkt_s rx_pkt
);
  import tups_pkg::*;

  logic tx_vld_r;
  tups_pkt_s tx_pkt_r;
  tups_pkt_s pkt_nxt;
  logic [15:0] grp_port;
  logic [15:0] node_dst;
  logic udp_nxt;

  // ****************************************
  // port choices
  // ****************************************
  assign grp_port = (cfg_grp_pick < cfg_grp_lo) ? cfg_grp_lo :
                    (cfg_grp_pick > cfg_grp_hi) ? cfg_grp_hi : cfg_grp_pick; // [RULE14]
  assign node_dst = node_adv_vld ? node_adv_port : node_ctl_port; // [RULE13] [RULE20]
  assign udp_nxt = (cmd_kind == TUPS_CONN_REQ) ? (cfg_udp_en & link.node_cap) : udp_on; // [RULE5]

  // descriptor for the next command
  always_comb
  begin
    pkt_nxt = '0;
    pkt_nxt.kind = cmd_kind;
    pkt_nxt.dir = cmd_dir;
    pkt_nxt.v6 = cfg_v6; // [RULE2]
    pkt_nxt.udp = udp_nxt;
    pkt_nxt.dscp = cfg_dscp; // [RULE1]
    pkt_nxt.udp_hdr = udp_nxt ? {cfg_ctl_port, node_ctl_port} : 32'h00000000; // [RULE9] [RULE22]
    case (cmd_kind)
      TUPS_CONN_REQ:
      begin
        pkt_nxt.udp_hdr = udp_nxt ? {cfg_ctl_port, `TUPS_WELL_KNOWN_PORT} : 32'h00000000; // [RULE7]
        pkt_nxt.prio_vld = (cfg_dscp != 6'h00);
        pkt_nxt.prio = cfg_dscp;
      end
      TUPS_SESS_REQ:
      begin
        pkt_nxt.attr_vld = cfg_adv_src; // [RULE16]
        pkt_nxt.attr_port = cfg_src_port;
        pkt_nxt.grp_vld = (cmd_dir == TUPS_DN_GRP); // [RULE14]
        pkt_nxt.grp_port = grp_port;
      end
      TUPS_DATA:
      begin
        if (cmd_dir == TUPS_DN_GRP)
          pkt_nxt.udp_hdr = udp_nxt ? {cfg_src_port, grp_port} : 32'h00000000; // [RULE14] [RULE16]
        else
          pkt_nxt.udp_hdr = udp_nxt ? {cfg_src_port, node_dst} : 32'h00000000; // [RULE13] [RULE20]
      end
      default: pkt_nxt.kind = TUPS_CTRL;
    endcase
  end

  // ****************************************
  // transmit register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_vld_r <= 1'b0;
      tx_pkt_r <= '0;
    end
    else
    begin
      tx_vld_r <= cmd_vld;
      tx_pkt_r <= pkt_nxt;
    end
  end

  assign link.c2n_vld = tx_vld_r;
  assign link.c2n_pkt = tx_pkt_r;

  // ****************************************
  // negotiated state and receive capture
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      udp_on <= 1'b0;
      node_ctl_port <= `TUPS_WELL_KNOWN_PORT;
      node_adv_vld <= 1'b0;
      node_adv_port <= 16'h0000;
    end
    else
    begin
      if (cmd_vld && cmd_kind == TUPS_CONN_REQ)
      begin
        udp_on <= udp_nxt; // [RULE5]
        node_adv_vld <= 1'b0;
      end
      else if (link.n2c_vld && link.n2c_pkt.kind == TUPS_SESS_REP)
      begin
        node_adv_vld <= link.n2c_pkt.attr_vld; // [RULE13] [RULE20]
        node_adv_port <= link.n2c_pkt.attr_port;
      end
      if (link.n2c_vld && link.n2c_pkt.kind == TUPS_CONN_REP)
        node_ctl_port <= link.n2c_pkt.udp_hdr[31:16]; // reply source port [RULE9]
    end
  end

  // every node packet offered to the user, with or without udp
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_vld <= 1'b0;
      rx_pkt <= '0;
    end
    else
    begin
      rx_vld <= link.n2c_vld; // [RULE2] [RULE5]
      rx_pkt <= link.n2c_pkt;
    end
  end
endmodule // tups_core

// *** verification/tups_monitor.sv ***
// assertion monitor watching the link between the two tunnel udp ends
`timescale 1ns/100ps
`include "tups_consts.svh"
module tups_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic c2n_vld,
  input wire tups_pkg::tups_pkt_s c2n_pkt,
  input wire logic n2c_vld,
  input wire tups_pkg::tups_pkt_s n2c_pkt,
  input wire logic node_cap
);
  import tups_pkg::*;
  logic [15:0] host_r, cadv_r, rsrc_r, dsrc_r;
  logic [5:0] prio_r;
  logic cadv_v, dsrc_v, creq, nctl, ndat, cadv;
  // decoded link events
  assign creq = c2n_vld && c2n_pkt.kind == TUPS_CONN_REQ;
  assign cadv = c2n_vld && c2n_pkt.kind == TUPS_SESS_REQ;
  assign nctl = n2c_vld && n2c_pkt.kind == TUPS_CTRL && n2c_pkt.udp;
  assign ndat = n2c_vld && n2c_pkt.kind == TUPS_DATA && n2c_pkt.udp;
  // ports and priority the core has handed out
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      host_r <= `TUPS_WELL_KNOWN_PORT;
      cadv_v <= 1'b0;
      cadv_r <= 16'h0000;
      prio_r <= 6'h00;
    end
    else
    begin
      if (creq)
        host_r <= c2n_pkt.udp_hdr[31:16];
      if (creq)
        cadv_v <= 1'b0;
      else if (cadv)
        cadv_v <= c2n_pkt.attr_vld;
      if (cadv)
        cadv_r <= c2n_pkt.attr_port;
      // a request without the attribute falls back to best effort
      if (creq)
        prio_r <= c2n_pkt.prio_vld ? c2n_pkt.prio : 6'h00;
      else if (c2n_vld && c2n_pkt.prio_vld)
        prio_r <= c2n_pkt.prio;
    end
  // ports the node has used so far
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rsrc_r <= `TUPS_RST_CTL_PORT;
      dsrc_v <= 1'b0;
      dsrc_r <= 16'h0000;
    end
    else
    begin
      if (n2c_vld && n2c_pkt.kind == TUPS_CONN_REP)
        rsrc_r <= n2c_pkt.udp_hdr[31:16];
      if (ndat)
        dsrc_v <= 1'b1;
      if (ndat)
        dsrc_r <= n2c_pkt.udp_hdr[31:16];
    end
  // **********
  // checks
  // **********
  default clocking mon_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_conn_reply_due:
    assert property (creq |-> ##2 n2c_vld && n2c_pkt.kind == TUPS_CONN_REP) else $error("late reply");
  a_reply_to_host:
    assert property (creq && c2n_pkt.udp && node_cap |-> ##2 n2c_pkt.udp &&
      n2c_pkt.udp_hdr[15:0] == $past(c2n_pkt.udp_hdr[31:16], 2)) else $error("bad reply port");
  a_plain_reply:
    assert property (creq && !c2n_pkt.udp |-> ##2 !n2c_pkt.udp && n2c_pkt.udp_hdr == 32'h0) else $error("udp added");
  a_ctl_ports:
    assert property (nctl |-> n2c_pkt.udp_hdr == {rsrc_r, host_r}) else $error("bad control ports");
  a_ctl_prio:
    assert property (n2c_vld && n2c_pkt.kind inside {TUPS_CONN_REP, TUPS_CTRL, TUPS_SESS_REP} |->
      n2c_pkt.dscp == prio_r) else $error("bad control priority");
  a_adv_outside:
    assert property (n2c_vld && n2c_pkt.kind == TUPS_SESS_REP && n2c_pkt.attr_vld |-> n2c_pkt.dir != TUPS_DN_GRP &&
      (n2c_pkt.attr_port < `TUPS_RST_WIN_LO || n2c_pkt.attr_port > `TUPS_RST_WIN_HI)) else $error("window port");
  a_data_dst:
    assert property (ndat |-> n2c_pkt.udp_hdr[15:0] == (cadv_v ? cadv_r : host_r)) else $error("bad data dst");
  a_data_src_fixed:
    assert property (ndat && dsrc_v |-> n2c_pkt.udp_hdr[31:16] == dsrc_r) else $error("data src moved");
  c_conn_udp: cover property (creq && c2n_pkt.udp);
  c_adv_rep: cover property (n2c_vld && n2c_pkt.attr_vld);
  c_data_udp: cover property (ndat);
endmodule // tups_monitor

// *** verification/tb_top.sv ***
// bench driving both tunnel udp ends and judging the link
`timescale 1ns/100ps
`include "tups_consts.svh"
module tb_top;
  import tups_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic cfg_udp_en, cfg_v6, cfg_adv_src, cmd_vld, udp_on, node_adv_vld, rx_vld;
  logic [5:0] cfg_dscp;
  logic [15:0] cfg_ctl_port, cfg_src_port, cfg_grp_lo, cfg_grp_hi, cfg_grp_pick, node_ctl_port, node_adv_port;
  tups_kind_e cmd_kind;
  tups_dir_e cmd_dir;
  tups_pkt_s rx_pkt, cp, rp;
  int mismatches, samples_checked;
  assign hready = hreadyout;
  tups_link_if lk ();
  tups_node u_tups_node (.hclk, .hresetn, .link(lk), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata);
  tups_core u_tups_core (.hclk, .hresetn, .link(lk), .cfg_udp_en, .cfg_v6, .cfg_dscp, .cfg_ctl_port, .cfg_src_port,
    .cfg_adv_src, .cfg_grp_lo, .cfg_grp_hi, .cfg_grp_pick, .cmd_vld, .cmd_kind, .cmd_dir, .udp_on, .node_ctl_port,
    .node_adv_vld, .node_adv_port, .rx_vld, .rx_pkt);
  tups_monitor u_tups_monitor (.hclk, .hresetn, .c2n_vld(lk.c2n_vld), .c2n_pkt(lk.c2n_pkt), .n2c_vld(lk.n2c_vld),
    .n2c_pkt(lk.n2c_pkt), .node_cap(lk.node_cap));
  // 40 mhz clock
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single-word bus transfer; read data lands in q
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wait_rx();
    do
    begin
      @(posedge hclk);
      #1;
    end
    while (rx_vld !== 1'b1);
    rp = rx_pkt;
  endtask
  // core command pulse, then catch the descriptor it puts on the link
  task automatic send(input tups_kind_e k, input tups_dir_e d);
    @(posedge hclk);
    cmd_vld <= 1'b1;
    cmd_kind <= k;
    cmd_dir <= d;
    @(posedge hclk);
    cmd_vld <= 1'b0;
    // the link valid stands for one cycle only, so look right after this edge
    #1;
    while (lk.c2n_vld !== 1'b1)
    begin
      @(posedge hclk);
      #1;
    end
    cp = lk.c2n_pkt;
  endtask
  task automatic t_regs();
    ahb(1'b0, `TUPS_OFS_CTRL, 32'h0);
    chk(q, 32'h00000003);
    chk(32'(hresp), 32'h00000000);
    ahb(1'b0, `TUPS_OFS_PORTS, 32'h0);
    chk(q, 32'h06A506A5);
    ahb(1'b0, `TUPS_OFS_WINDOW, 32'h0);
    chk(q, 32'hC0FFC000);
    ahb(1'b1, 8'h18, 32'hFFFFFFFF);
    ahb(1'b0, 8'h18, 32'h0);
    chk(q, 32'h00000000);
    ahb(1'b1, `TUPS_OFS_PORTS, 32'h22223333);
    ahb(1'b0, `TUPS_OFS_PORTS, 32'h0);
    chk(q, 32'h22223333);
  endtask
  task automatic t_conn();
    send(TUPS_CONN_REQ, TUPS_DN_UNI);
    chk(cp.udp_hdr, {16'h1234, `TUPS_WELL_KNOWN_PORT});
    wait_rx;
    chk(32'({rp.kind, rp.udp, rp.v6}), 32'({TUPS_CONN_REP, 2'h3}));
    chk(rp.udp_hdr, 32'h33331234);
    chk(32'({udp_on, node_ctl_port}), 32'h00013333);
    send(TUPS_CTRL, TUPS_DN_UNI);
    chk(cp.udp_hdr, 32'h12343333);
    ahb(1'b0, `TUPS_OFS_STATUS, 32'h0);
    chk(q, 32'h00000003);
    ahb(1'b1, `TUPS_OFS_CMD, 32'h0);
    wait_rx;
    chk(rp.udp_hdr, 32'h33331234);
    chk(32'({rp.kind, rp.dscp}), 32'({TUPS_CTRL, 6'h00}));
  endtask
  task automatic t_sess();
    send(TUPS_SESS_REQ, TUPS_UP);
    wait_rx;
    chk(32'({rp.kind, rp.attr_vld, rp.attr_port}), 32'({TUPS_SESS_REP, 17'h12222}));
    chk(32'({node_adv_vld, node_adv_port}), 32'h00012222);
    ahb(1'b1, `TUPS_OFS_CMD, 32'h5);
    wait_rx;
    chk(rp.udp_hdr, 32'h22221234);
    send(TUPS_DATA, TUPS_UP);
    chk(32'(cp.udp_hdr[15:0]), 32'h00002222);
    @(posedge hclk) cfg_adv_src <= 1'b1;
    send(TUPS_SESS_REQ, TUPS_DN_UNI);
    chk(32'({cp.attr_vld, cp.attr_port}), 32'h00015555);
    wait_rx;
    ahb(1'b1, `TUPS_OFS_CMD, 32'h1);
    wait_rx;
    chk(rp.udp_hdr, 32'h22225555);
    ahb(1'b0, `TUPS_OFS_PEERS, 32'h0);
    chk(q, 32'h55551234);
    send(TUPS_DATA, TUPS_DN_UNI);
    chk(cp.udp_hdr, 32'h55552222);
  endtask
  task automatic t_grp();
    send(TUPS_SESS_REQ, TUPS_DN_GRP);
    chk(32'({cp.grp_vld, cp.grp_port}), 32'h0001C010);
    wait_rx;
    chk(32'(rp.attr_vld), 32'h0);
    @(posedge hclk) cfg_grp_pick <= 16'hD000;
    send(TUPS_SESS_REQ, TUPS_DN_GRP);
    chk(32'(cp.grp_port), 32'h0000C0FF);
    wait_rx;
    ahb(1'b1, `TUPS_OFS_PORTS, 32'hC0FF3333);
    send(TUPS_SESS_REQ, TUPS_DN_UNI);
    wait_rx;
    chk(32'(rp.attr_vld), 32'h0);
    send(TUPS_DATA, TUPS_DN_UNI);
    chk(cp.udp_hdr, 32'h55553333);
  endtask
  task automatic t_plain();
    ahb(1'b1, `TUPS_OFS_CTRL, 32'h2);
    @(posedge hclk) cfg_dscp <= 6'h2E;
    send(TUPS_CONN_REQ, TUPS_DN_UNI);
    chk(32'({cp.udp, cp.prio_vld, cp.prio, cp.dscp}), 32'({2'h1, 6'h2E, 6'h2E}));
    wait_rx;
    chk(32'({rp.udp, rp.dscp}), 32'h0000002E);
    chk(rp.udp_hdr, 32'h0);
    chk(32'(udp_on), 32'h0);
    ahb(1'b0, `TUPS_OFS_STATUS, 32'h0);
    chk(q, 32'h000002E2);
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cfg_udp_en = 1'b1;
    cfg_v6 = 1'b1;
    cfg_dscp = 6'h00;
    cfg_ctl_port = 16'h1234;
    cfg_src_port = 16'h5555;
    cfg_adv_src = 1'b0;
    cfg_grp_lo = 16'hC000;
    cfg_grp_hi = 16'hC0FF;
    cfg_grp_pick = 16'hC010;
    cmd_vld = 1'b0;
    cmd_kind = TUPS_CONN_REQ;
    cmd_dir = TUPS_DN_UNI;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_conn();
    t_sess();
    t_grp();
    t_plain();
    finish_test();
  end
  // cut a hung run short
  initial
  begin
    #200000;
    mismatches++;
    finish_test();
  end
endmodule // tb_top
